// *** dsp_cfg_pkg.sv ***
// constants and types for the start-up configuration register block
package dsp_cfg_pkg;
   // control-port geometry
   localparam int ADDR_W = 16;
   localparam int DATA_W = 16;
   // register addresses on the control port
   localparam logic [15:0] ADDR_PLL_FEEDBACK = 16'hF000;
   localparam logic [15:0] ADDR_PLL_PRESCALE = 16'hF001;
   localparam logic [15:0] ADDR_CLK_SOURCE = 16'hF002;
   localparam logic [15:0] ADDR_PLL_RUN = 16'hF003;
   localparam logic [15:0] ADDR_PLL_LOCK = 16'hF004;
   localparam logic [15:0] ADDR_CLK_OUTPUT = 16'hF005;
   localparam logic [15:0] ADDR_POWER_FIRST = 16'hF050;
   localparam logic [15:0] ADDR_POWER_SECOND = 16'hF051;
   localparam logic [15:0] ADDR_HIBERNATE = 16'hF400;
   localparam logic [15:0] ADDR_FRAME_PULSE = 16'hF401;
   localparam logic [15:0] ADDR_CORE_RUN = 16'hF402;
   localparam logic [15:0] ADDR_ENTRY_POINT = 16'hF404;
   localparam logic [15:0] ADDR_SOFT_RESET = 16'hF890;
   // memory windows: below the register base everything is RAM
   localparam logic [15:0] ADDR_REG_BASE = 16'hF000;
   localparam logic [15:0] ADDR_PROGRAM_RAM = 16'hC000;
   localparam logic [15:0] ADDR_DATA_BANK_A = 16'h0000;
   localparam logic [15:0] ADDR_DATA_BANK_B = 16'h6000;
   // reset values and field codes
   localparam logic [15:0] RST_PLL_FEEDBACK = 16'h0060;
   localparam logic [15:0] RST_ZERO = 16'h0000;
   localparam logic [15:0] RST_SOFT_RESET = 16'h0001;
   localparam logic [15:0] FRAME_PULSE_INTERNAL = 16'h0002;
   localparam logic [15:0] CLK_OUTPUT_OFF = 16'h0000;
   localparam int ENABLE_BIT = 0;
   localparam int LOCK_BIT = 0;
   localparam int PRESCALE_LSB = 0;
   localparam int PRESCALE_W = 2;
   // slave-select rises needed to enter spi mode
   localparam logic [1:0] SPI_TOGGLES = 2'h3;
   // timing
   localparam int CLK_PERIOD_NS = 4;
   localparam int PLL_LOCK_TIME_NS = 10666000;
   localparam int PLL_LOCK_CYCLES = PLL_LOCK_TIME_NS / CLK_PERIOD_NS;
   localparam int INIT_TIME_NS = 50000;
   localparam int INIT_CYCLES = (INIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int TIMER_W = 32;

   // one control-port request
   typedef struct packed {
      logic wr;
      logic rd;
      logic [15:0] addr;
      logic [15:0] wdata;
   } ctrl_req_t;

   // software-visible configuration registers
   typedef struct packed {
      logic [15:0] pll_feedback_divider;
      logic [15:0] pll_input_prescaler;
      logic [15:0] core_clock_source_select;
      logic [15:0] pll_run_control;
      logic [15:0] clock_output_control;
      logic [15:0] subsystem_power_first;
      logic [15:0] subsystem_power_second;
      logic [15:0] core_hibernate;
      logic [15:0] frame_pulse_select;
      logic [15:0] core_run_control;
      logic [15:0] program_entry_point;
      logic [15:0] soft_reset_control;
   } cfg_regs_t;

   // pll sequencing
   typedef enum logic [1:0] {PLL_OFF, PLL_LOCKING, PLL_LOCKED} pll_state_t;
endpackage

// *** interval_timer.sv ***
// one-shot interval timer: pulses done a fixed count after start
module interval_timer #(
   parameter int unsigned CYCLES = 1
) (
   input wire logic core_clk_in,
   input wire logic srst_in,
   input wire logic start_in,
   input wire logic abort_in,
   output logic busy_out,
   output logic done_out
);
   // timer state
   typedef struct packed {
      logic busy;
      logic done;
      logic [dsp_cfg_pkg::TIMER_W-1:0] cnt;
   } timer_state_t;

   timer_state_t s;
   timer_state_t next_s;

   // countdown, abort wins over a running count
   always_comb begin
      next_s = s;
      next_s.done = 1'b0;
      if (abort_in) begin
         next_s.busy = 1'b0;
      end else if (start_in) begin
         next_s.busy = 1'b1;
         next_s.cnt = (dsp_cfg_pkg::TIMER_W)'(CYCLES - 1);
      end else if (s.busy) begin
         if (s.cnt == '0) begin
            next_s.busy = 1'b0;
            next_s.done = 1'b1;
         end else begin
            next_s.cnt = s.cnt - 1'b1;
         end
      end
   end

   // state register
   always_ff @(posedge core_clk_in) begin
      if (srst_in) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign busy_out = s.busy;
   assign done_out = s.done;
endmodule

// *** dsp_startup_config_sequence.sv ***
// start-up configuration registers, pll lock sequencing and core run control
// Function
// - feedback divider defaults to 0x60 (96)
// - prescaler code 0x02 divides master clock by 4
// - clock source 0x01 selects pll for core
// - clock output 0x05 enables output pin
// - writes fail while locking; lock bit readable
// - first power register powers major subsystems
// - entry point register sets start instruction
// - frame pulse select 0x02 means internal
module dsp_startup_config_sequence #(
   parameter int unsigned LOCK_CYCLES = dsp_cfg_pkg::PLL_LOCK_CYCLES,
   parameter int unsigned INIT_WAIT_CYCLES = dsp_cfg_pkg::INIT_CYCLES
) (
   input wire logic core_clk_in,
   input wire logic srst_in,
   input wire logic slave_select_address_zero_in,
   input wire dsp_cfg_pkg::ctrl_req_t ctrl_in,
   output logic [15:0] rdata_out,
   output logic rvalid_out,
   output logic ctrl_fail_out,
   output logic spi_mode_out,
   output dsp_cfg_pkg::cfg_regs_t cfg_out,
   output logic soft_reset_active_out,
   output logic [3:0] pll_input_div_out,
   output logic core_clk_from_pll_out,
   output logic clock_output_pin_enable_out,
   output logic pll_locked_out,
   output logic frame_pulse_internal_out,
   output logic core_running_out,
   output logic init_done_out,
   output logic mem_wr_out,
   output logic mem_prog_sel_out,
   output logic [15:0] mem_addr_out,
   output logic [15:0] mem_data_out
);
   // whole module state
   typedef struct packed {
      dsp_cfg_pkg::cfg_regs_t cfg;
      dsp_cfg_pkg::pll_state_t pll_state;
      logic ss_prev;
      logic [1:0] ss_rises;
      logic spi_mode;
      logic lock_start;
      logic init_start;
      logic init_done;
      logic [15:0] rdata;
      logic rvalid;
      logic fail;
      logic soft_active;
      logic [3:0] input_div;
      logic clk_from_pll;
      logic clock_output_pin_en;
      logic locked;
      logic frame_internal;
      logic running;
      logic mem_wr;
      logic mem_prog;
      logic [15:0] mem_addr;
      logic [15:0] mem_data;
   } top_state_t;

   top_state_t s;
   top_state_t next_s;
   logic lock_done; // pll lock timer expired
   logic init_elapsed; // post-start wait expired
   logic port_open; // control port alive
   logic in_soft; // soft reset held
   logic wr_ok; // write accepted this cycle
   logic rd_ok; // read accepted this cycle

   // defaults restored at power-on and by soft reset
   function automatic dsp_cfg_pkg::cfg_regs_t cfg_defaults();
      dsp_cfg_pkg::cfg_regs_t c;
      c = '0;
      c.pll_feedback_divider = dsp_cfg_pkg::RST_PLL_FEEDBACK;
      c.clock_output_control = dsp_cfg_pkg::CLK_OUTPUT_OFF;
      c.soft_reset_control = dsp_cfg_pkg::RST_SOFT_RESET;
      return c;
   endfunction

   // emulated pll lock time
   interval_timer #(.CYCLES(LOCK_CYCLES)) lock_timer (
      .core_clk_in(core_clk_in),
      .srst_in(srst_in),
      .start_in(s.lock_start),
      .abort_in(s.pll_state == dsp_cfg_pkg::PLL_OFF),
      .busy_out(),
      .done_out(lock_done)
   );

   // wait for the core's init program after start
   interval_timer #(.CYCLES(INIT_WAIT_CYCLES)) init_timer (
      .core_clk_in(core_clk_in),
      .srst_in(srst_in),
      .start_in(s.init_start),
      .abort_in(!s.running),
      .busy_out(),
      .done_out(init_elapsed)
   );

   assign port_open = (s.pll_state != dsp_cfg_pkg::PLL_LOCKING);
   assign in_soft = !s.cfg.soft_reset_control[dsp_cfg_pkg::ENABLE_BIT];
   // only soft-reset register writable in soft reset
   assign wr_ok = ctrl_in.wr && port_open
      && (!in_soft || ctrl_in.addr == dsp_cfg_pkg::ADDR_SOFT_RESET);
   assign rd_ok = ctrl_in.rd && port_open;

   // next-state logic
   always_comb begin
      next_s = s;
      next_s.rvalid = 1'b0;
      next_s.fail = 1'b0;
      next_s.mem_wr = 1'b0;
      next_s.lock_start = 1'b0;
      next_s.init_start = 1'b0;
      next_s.ss_prev = slave_select_address_zero_in;
      // count slave-select rises up to spi mode
      if (slave_select_address_zero_in && !s.ss_prev && !s.spi_mode) begin
         next_s.ss_rises = s.ss_rises + 2'h1;
         if (s.ss_rises + 2'h1 == dsp_cfg_pkg::SPI_TOGGLES) begin
            next_s.spi_mode = 1'b1;
         end
      end
      // refused access shows as fail pulse
      if ((ctrl_in.wr && !wr_ok) || (ctrl_in.rd && !rd_ok)) begin
         next_s.fail = 1'b1;
      end
      // lock timer completion
      if (lock_done && s.pll_state == dsp_cfg_pkg::PLL_LOCKING) begin
         next_s.pll_state = dsp_cfg_pkg::PLL_LOCKED;
      end
      if (init_elapsed) begin
         next_s.init_done = 1'b1;
      end
      if (wr_ok) begin
         if (ctrl_in.addr < dsp_cfg_pkg::ADDR_REG_BASE) begin
            // RAM write forwarded, program window flagged
            next_s.mem_wr = 1'b1;
            next_s.mem_addr = ctrl_in.addr;
            next_s.mem_data = ctrl_in.wdata;
            next_s.mem_prog = (ctrl_in.addr >= dsp_cfg_pkg::ADDR_PROGRAM_RAM);
         end else begin
            unique case (ctrl_in.addr)
               dsp_cfg_pkg::ADDR_PLL_FEEDBACK: next_s.cfg.pll_feedback_divider = ctrl_in.wdata;
               dsp_cfg_pkg::ADDR_PLL_PRESCALE: next_s.cfg.pll_input_prescaler = ctrl_in.wdata;
               dsp_cfg_pkg::ADDR_CLK_SOURCE: next_s.cfg.core_clock_source_select = ctrl_in.wdata;
               dsp_cfg_pkg::ADDR_CLK_OUTPUT: next_s.cfg.clock_output_control = ctrl_in.wdata;
               dsp_cfg_pkg::ADDR_POWER_FIRST: next_s.cfg.subsystem_power_first = ctrl_in.wdata;
               dsp_cfg_pkg::ADDR_POWER_SECOND: next_s.cfg.subsystem_power_second = ctrl_in.wdata;
               dsp_cfg_pkg::ADDR_HIBERNATE: next_s.cfg.core_hibernate = ctrl_in.wdata;
               dsp_cfg_pkg::ADDR_FRAME_PULSE: next_s.cfg.frame_pulse_select = ctrl_in.wdata;
               dsp_cfg_pkg::ADDR_ENTRY_POINT: next_s.cfg.program_entry_point = ctrl_in.wdata;
               dsp_cfg_pkg::ADDR_PLL_RUN: begin
                  // enable restarts lock attempt, disable drops lock
                  next_s.cfg.pll_run_control = ctrl_in.wdata;
                  if (ctrl_in.wdata[dsp_cfg_pkg::ENABLE_BIT]) begin
                     next_s.pll_state = dsp_cfg_pkg::PLL_LOCKING;
                     next_s.lock_start = 1'b1;
                  end else begin
                     next_s.pll_state = dsp_cfg_pkg::PLL_OFF;
                  end
               end
               dsp_cfg_pkg::ADDR_CORE_RUN: begin
                  // start edge arms init wait, stop clears it
                  next_s.cfg.core_run_control = ctrl_in.wdata;
                  if (!ctrl_in.wdata[dsp_cfg_pkg::ENABLE_BIT]) begin
                     next_s.init_done = 1'b0;
                  end else if (!s.cfg.core_run_control[dsp_cfg_pkg::ENABLE_BIT]) begin
                     next_s.init_start = 1'b1;
                     next_s.init_done = 1'b0;
                  end
               end
               dsp_cfg_pkg::ADDR_SOFT_RESET: begin
                  if (!ctrl_in.wdata[dsp_cfg_pkg::ENABLE_BIT]) begin
                     next_s.cfg = cfg_defaults();
                     next_s.pll_state = dsp_cfg_pkg::PLL_OFF;
                     next_s.init_done = 1'b0;
                  end
                  next_s.cfg.soft_reset_control = ctrl_in.wdata;
               end
               default: ; // unmapped register write ignored
            endcase
         end
      end
      // register read, unmapped reads zero
      if (rd_ok) begin
         next_s.rvalid = 1'b1;
         unique case (ctrl_in.addr)
            dsp_cfg_pkg::ADDR_PLL_FEEDBACK: next_s.rdata = s.cfg.pll_feedback_divider;
            dsp_cfg_pkg::ADDR_PLL_PRESCALE: next_s.rdata = s.cfg.pll_input_prescaler;
            dsp_cfg_pkg::ADDR_CLK_SOURCE: next_s.rdata = s.cfg.core_clock_source_select;
            dsp_cfg_pkg::ADDR_PLL_RUN: next_s.rdata = s.cfg.pll_run_control;
            dsp_cfg_pkg::ADDR_PLL_LOCK: next_s.rdata = {15'h0000, s.locked};
            dsp_cfg_pkg::ADDR_CLK_OUTPUT: next_s.rdata = s.cfg.clock_output_control;
            dsp_cfg_pkg::ADDR_POWER_FIRST: next_s.rdata = s.cfg.subsystem_power_first;
            dsp_cfg_pkg::ADDR_POWER_SECOND: next_s.rdata = s.cfg.subsystem_power_second;
            dsp_cfg_pkg::ADDR_HIBERNATE: next_s.rdata = s.cfg.core_hibernate;
            dsp_cfg_pkg::ADDR_FRAME_PULSE: next_s.rdata = s.cfg.frame_pulse_select;
            dsp_cfg_pkg::ADDR_CORE_RUN: next_s.rdata = s.cfg.core_run_control;
            dsp_cfg_pkg::ADDR_ENTRY_POINT: next_s.rdata = s.cfg.program_entry_point;
            dsp_cfg_pkg::ADDR_SOFT_RESET: next_s.rdata = s.cfg.soft_reset_control;
            default: next_s.rdata = dsp_cfg_pkg::RST_ZERO;
         endcase
      end
      // decoded outputs follow the new register values
      next_s.soft_active = !next_s.cfg.soft_reset_control[dsp_cfg_pkg::ENABLE_BIT];
      // prescaler code n divides by 2**n
      next_s.input_div = 4'h1
         << next_s.cfg.pll_input_prescaler[dsp_cfg_pkg::PRESCALE_LSB +: dsp_cfg_pkg::PRESCALE_W];
      next_s.clk_from_pll = next_s.cfg.core_clock_source_select[dsp_cfg_pkg::ENABLE_BIT];
      // any nonzero setting enables the pin
      next_s.clock_output_pin_en = (next_s.cfg.clock_output_control != dsp_cfg_pkg::CLK_OUTPUT_OFF);
      next_s.locked = (next_s.pll_state == dsp_cfg_pkg::PLL_LOCKED);
      next_s.frame_internal = (next_s.cfg.frame_pulse_select == dsp_cfg_pkg::FRAME_PULSE_INTERNAL);
      // hibernate halts core regardless of run
      next_s.running = next_s.cfg.core_run_control[dsp_cfg_pkg::ENABLE_BIT]
         && !next_s.cfg.core_hibernate[dsp_cfg_pkg::ENABLE_BIT] && !next_s.soft_active;
   end

   // state register
   always_ff @(posedge core_clk_in) begin
      if (srst_in) begin
         s <= '0;
         // idle pin level, so no false rise follows reset
         s.ss_prev <= 1'b1;
         s.cfg <= cfg_defaults();
         s.input_div <= 4'h1;
      end else begin
         s <= next_s;
      end
   end

   // outputs, all straight from the state register
   assign rdata_out = s.rdata;
   assign rvalid_out = s.rvalid;
   assign ctrl_fail_out = s.fail;
   assign spi_mode_out = s.spi_mode;
   assign cfg_out = s.cfg;
   assign soft_reset_active_out = s.soft_active;
   assign pll_input_div_out = s.input_div;
   assign core_clk_from_pll_out = s.clk_from_pll;
   assign clock_output_pin_enable_out = s.clock_output_pin_en;
   assign pll_locked_out = s.locked;
   assign frame_pulse_internal_out = s.frame_internal;
   assign core_running_out = s.running;
   assign init_done_out = s.init_done;
   assign mem_wr_out = s.mem_wr;
   assign mem_prog_sel_out = s.mem_prog;
   assign mem_addr_out = s.mem_addr;
   assign mem_data_out = s.mem_data;

   // checks
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (srst_in);

   a_fail_when_locking: assert property (
      (ctrl_in.wr && s.pll_state == dsp_cfg_pkg::PLL_LOCKING) |=> ctrl_fail_out && !mem_wr_out)
      else $error("write during lock not refused");
   a_lock_bit_read: assert property (
      (rd_ok && ctrl_in.addr == dsp_cfg_pkg::ADDR_PLL_LOCK)
      |=> rvalid_out && rdata_out[0] == $past(pll_locked_out))
      else $error("lock bit readback wrong");
   a_divider_default: assert property (
      $fell(srst_in) |-> cfg_out.pll_feedback_divider == dsp_cfg_pkg::RST_PLL_FEEDBACK)
      else $error("feedback divider default wrong");
   a_prescale_ratio: assert property (
      (wr_ok && ctrl_in.addr == dsp_cfg_pkg::ADDR_PLL_PRESCALE && ctrl_in.wdata == 16'h0002)
      |=> pll_input_div_out == 4'h4)
      else $error("prescale not by four");
   a_clock_from_pll: assert property (
      (wr_ok && ctrl_in.addr == dsp_cfg_pkg::ADDR_CLK_SOURCE && ctrl_in.wdata == 16'h0001)
      |=> core_clk_from_pll_out)
      else $error("pll not core clock");
   a_clock_output_pin_enable: assert property (
      (wr_ok && ctrl_in.addr == dsp_cfg_pkg::ADDR_CLK_OUTPUT && ctrl_in.wdata == 16'h0005)
      |=> clock_output_pin_enable_out)
      else $error("clock output not enabled");
   a_power_first: assert property (
      (wr_ok && ctrl_in.addr == dsp_cfg_pkg::ADDR_POWER_FIRST)
      |=> cfg_out.subsystem_power_first == $past(ctrl_in.wdata))
      else $error("power register not stored");
   a_entry_point: assert property (
      (wr_ok && ctrl_in.addr == dsp_cfg_pkg::ADDR_ENTRY_POINT)
      |=> cfg_out.program_entry_point == $past(ctrl_in.wdata))
      else $error("entry point not stored");
   a_frame_internal: assert property (
      frame_pulse_internal_out
      == (cfg_out.frame_pulse_select == dsp_cfg_pkg::FRAME_PULSE_INTERNAL))
      else $error("frame source decode wrong");
   a_soft_reset_enter: assert property (
      (wr_ok && ctrl_in.addr == dsp_cfg_pkg::ADDR_SOFT_RESET && ctrl_in.wdata == 16'h0000)
      |=> soft_reset_active_out && !core_running_out ##1 soft_reset_active_out)
      else $error("soft reset not entered");
   a_run_gating: assert property (
      core_running_out |-> cfg_out.core_run_control[0] && !cfg_out.core_hibernate[0])
      else $error("core runs while stopped or hibernating");
   a_hibernate_stops: assert property (
      (wr_ok && ctrl_in.addr == dsp_cfg_pkg::ADDR_HIBERNATE && ctrl_in.wdata[0])
      |=> !core_running_out)
      else $error("hibernate did not halt core");

   c_spi_mode: cover property ($rose(spi_mode_out));
   c_locked: cover property ($rose(pll_locked_out));
   c_running: cover property ($rose(core_running_out));
   c_init_done: cover property ($rose(init_done_out));
endmodule

// *** host_model.sv ***
// host controller model driving the control port and the slave-select pin
module host_model (
   input wire logic core_clk_in,
   input wire logic [15:0] rdata_in,
   input wire logic rvalid_in,
   input wire logic ctrl_fail_in,
   output dsp_cfg_pkg::ctrl_req_t ctrl_out,
   output logic ss_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic last_fail; // refusal seen one cycle after the request
   logic last_rvalid; // read answer strobe seen
   logic [15:0] last_rdata; // read answer data
   // idle bus, slave select released high
   initial begin
      ctrl_out = '0;
      ss_out = 1'b1;
      last_fail = 1'b0;
      last_rvalid = 1'b0;
      last_rdata = 16'h0000;
   end
   // one request: launched at a falling edge, answer taken a cycle later
   // block writes issued word by word
   // no safeload used: bulk writes only
   task automatic xfer(input logic w, input logic r, input logic [15:0] a, input logic [15:0] d);
      @(negedge core_clk_in);
      ctrl_out = '{wr: w, rd: r, addr: a, wdata: d};
      @(negedge core_clk_in);
      // released lines show inverted values so nothing stale looks valid
      ctrl_out = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
      last_fail = ctrl_fail_in;
      last_rvalid = rvalid_in;
      last_rdata = rdata_in;
   endtask
   // slave-select toggles, each phase longer than a master clock
   task automatic ss_toggle(input int n);
      repeat (n) begin
         ss_out = 1'b0;
         repeat (4) @(negedge core_clk_in);
         ss_out = 1'b1;
         repeat (4) @(negedge core_clk_in);
      end
   endtask
endmodule

// *** dsp_startup_config_sequence_bench.sv ***
// self-checking bench for the start-up configuration block
module dsp_startup_config_sequence_bench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int LOCK_N = 20; // shortened lock time
   localparam int INIT_N = 10; // shortened init wait
   logic core_clk_in = 1'b0;
   logic srst_in = 1'b1;
   dsp_cfg_pkg::ctrl_req_t ctrl;
   dsp_cfg_pkg::cfg_regs_t cfg_out;
   logic ss, rvalid_out, ctrl_fail_out, spi_mode_out, soft_reset_active_out;
   logic core_clk_from_pll_out, clock_output_pin_enable_out, pll_locked_out, frame_pulse_internal_out;
   logic core_running_out, init_done_out, mem_wr_out, mem_prog_sel_out;
   logic [3:0] pll_input_div_out;
   logic [15:0] rdata_out, mem_addr_out, mem_data_out, val, adr;
   int n_fail = 0;
   int checks = 0;
   int seed = 33127;
   int cnt;
   // free-running core clock, 4 ns period
   always #2 core_clk_in = ~core_clk_in;
   host_model u_host (.core_clk_in(core_clk_in), .rdata_in(rdata_out), .rvalid_in(rvalid_out),
      .ctrl_fail_in(ctrl_fail_out), .ctrl_out(ctrl), .ss_out(ss));
   dsp_startup_config_sequence #(.LOCK_CYCLES(LOCK_N), .INIT_WAIT_CYCLES(INIT_N)) uut (
      .core_clk_in(core_clk_in), .srst_in(srst_in), .slave_select_address_zero_in(ss),
      .ctrl_in(ctrl), .rdata_out(rdata_out), .rvalid_out(rvalid_out),
      .ctrl_fail_out(ctrl_fail_out), .spi_mode_out(spi_mode_out), .cfg_out(cfg_out),
      .soft_reset_active_out(soft_reset_active_out), .pll_input_div_out(pll_input_div_out),
      .core_clk_from_pll_out(core_clk_from_pll_out), .clock_output_pin_enable_out(clock_output_pin_enable_out),
      .pll_locked_out(pll_locked_out), .frame_pulse_internal_out(frame_pulse_internal_out),
      .core_running_out(core_running_out), .init_done_out(init_done_out),
      .mem_wr_out(mem_wr_out), .mem_prog_sel_out(mem_prog_sel_out),
      .mem_addr_out(mem_addr_out), .mem_data_out(mem_data_out));
   // compare one value, count and report
   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // expected divide ratio for a prescaler code
   function automatic logic [15:0] div_of(input int code);
      return 16'(1 << (code % 4));
   endfunction
   // expected program-ram select for a ram address
   function automatic logic [15:0] prog_of(input logic [15:0] a);
      return {15'h0000, (a >= 16'hC000) && (a < 16'hF000)};
   endfunction
   // register write and read through the host
   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      u_host.xfer(1'b1, 1'b0, a, d);
   endtask
   task automatic rd(input logic [15:0] a, output logic [15:0] d);
      u_host.xfer(1'b0, 1'b1, a, 16'h0000);
      chk("read strobe", {15'h0000, u_host.last_rvalid}, 16'h0001);
      d = u_host.last_rdata;
   endtask
   // verdict and end of run
   task automatic close_out();
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // watchdog well beyond the expected run
   initial begin
      #60000;
      n_fail++;
      close_out();
   end
   // main sequence
   initial begin
      repeat (3) @(posedge core_clk_in);
      @(negedge core_clk_in);
      srst_in = 1'b0;
      chk("feedback reset", cfg_out.pll_feedback_divider, 16'h0060);
      chk("soft reset reg", cfg_out.soft_reset_control, 16'h0001);
      rd(16'hF000, val);
      chk("feedback read", val, 16'h0060);
      // spi mode only after the third rise
      u_host.ss_toggle(2);
      chk("spi early", {15'h0000, spi_mode_out}, 16'h0000);
      u_host.ss_toggle(1);
      chk("spi mode", {15'h0000, spi_mode_out}, 16'h0001);
      // soft reset enter, refused write, release
      wr(16'hF890, 16'h0000);
      chk("soft active", {15'h0000, soft_reset_active_out}, 16'h0001);
      wr(16'hF001, 16'h0002);
      chk("write in soft reset", {15'h0000, u_host.last_fail}, 16'h0001);
      wr(16'hF890, 16'h0001);
      chk("soft released", {15'h0000, soft_reset_active_out}, 16'h0000);
      // every prescaler code, ending on divide by 4
      for (int c = 0; c < 4; c++) begin
         wr(16'hF001, 16'(c ^ (c >> 1)));
         chk("input div", {12'h000, pll_input_div_out}, div_of(c ^ (c >> 1)));
      end
      wr(16'hF002, 16'h0001);
      chk("pll source", {15'h0000, core_clk_from_pll_out}, 16'h0001);
      wr(16'hF005, 16'h0005);
      chk("clock out", {15'h0000, clock_output_pin_enable_out}, 16'h0001);
      // pll enable: port refuses while locking
      wr(16'hF003, 16'h0001);
      u_host.xfer(1'b0, 1'b1, 16'hF004, 16'h0000);
      chk("read while locking", {15'h0000, u_host.last_fail}, 16'h0001);
      cnt = 0;
      while (pll_locked_out !== 1'b1 && cnt < 200) begin
         @(negedge core_clk_in);
         cnt++;
      end
      chk("lock time", 16'(cnt <= LOCK_N + 2), 16'h0001);
      rd(16'hF004, val);
      chk("lock bit", {15'h0000, val[0]}, 16'h0001);
      wr(16'hF050, 16'h4FFF);
      chk("power first", cfg_out.subsystem_power_first, 16'h4FFF);
      wr(16'hF051, 16'h0000);
      chk("power second", cfg_out.subsystem_power_second, 16'h0000);
      // hibernate, then random block downloads to the three windows
      wr(16'hF400, 16'h0001);
      for (int i = 0; i < 12; i++) begin
         adr = (i < 4 ? 16'hC000 : (i < 8 ? 16'h0000 : 16'h6000)) + 16'(i % 4);
         val = 16'($random(seed));
         wr(adr, val);
         chk("ram strobe", {15'h0000, mem_wr_out}, 16'h0001);
         chk("ram addr", mem_addr_out, adr);
         chk("ram data", mem_data_out, val);
         chk("ram select", {15'h0000, mem_prog_sel_out}, prog_of(adr));
      end
      val = 16'($random(seed));
      wr(16'hF404, val);
      rd(16'hF404, adr);
      chk("entry point", adr, val);
      wr(16'hF401, 16'h0001);
      chk("pulse other", {15'h0000, frame_pulse_internal_out}, 16'h0000);
      wr(16'hF401, 16'h0002);
      chk("pulse internal", {15'h0000, frame_pulse_internal_out}, 16'h0001);
      // wake, stop then start the core
      wr(16'hF400, 16'h0000);
      wr(16'hF402, 16'h0000);
      chk("core stopped", {15'h0000, core_running_out}, 16'h0000);
      wr(16'hF402, 16'h0001);
      chk("core running", {15'h0000, core_running_out}, 16'h0001);
      cnt = 0;
      while (init_done_out !== 1'b1 && cnt < 100) begin
         @(negedge core_clk_in);
         cnt++;
      end
      chk("init wait", 16'(cnt >= INIT_N - 2 && cnt <= INIT_N + 3), 16'h0001);
      wr(16'hF400, 16'h0001);
      chk("hibernated", {15'h0000, core_running_out}, 16'h0000);
      rd(16'hF100, val);
      chk("unmapped read", val, 16'h0000);
      close_out();
   end
endmodule
